// [src/kasumi_mode_control.sv]
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module kasumi_mode_control #(
  parameter int TAG_W = 32
) (
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  input  wire kmc_pkg::kmc_av_req_t av_req,
  output logic                      av_waitrequest,
  output logic [31:0]               av_readdata,
  input  wire kmc_pkg::kmc_ks_t     ks_in,
  output logic                      ks_ready,
  input  wire logic                 core_done,
  input  wire logic [TAG_W-1:0]     core_tag,
  output logic                      core_start,
  output logic                      core_f9,
  output logic                      core_init,
  output logic                      core_final,
  output logic [31:0]               core_bits,
  output logic                      writeback_req,
  output logic                      done_o,
  output logic                      error_o,
  output logic                      irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // bits of the next output word: a full word or the block tail
  function automatic logic [6:0] kmc_need(input logic [9:0] blk);
    kmc_need = (blk >= {3'h0, kmc_pkg::WORD_BITS}) ? kmc_pkg::WORD_BITS : blk[6:0];
  endfunction

  function automatic logic [31:0] kmc_mode_word(input kmc_pkg::kmc_mode_t m);
    kmc_mode_word = {24'h0, m.short_burst_format, m.compare_integrity, m.long_burst_format,
                     m.final_block_process, m.new_message_init, 1'b0, m.algorithm_select};
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic                  wait_r, wait_nxt;
  logic [31:0]           rdata_r, rdata_nxt;
  kmc_pkg::kmc_mode_t    mode_r, mode_nxt;
  logic [31:0]           dsize_r, dsize_nxt;
  logic [TAG_W-1:0]      etag_r, etag_nxt;
  logic [2:0]            cfg_r, cfg_nxt;      // wb a, wb b, long length
  logic [3:0]            ist_r, ist_nxt;
  logic [3:0]            ien_r, ien_nxt;
  logic [1:0]            cmp_r, cmp_nxt;
  kmc_pkg::kmc_state_t   st_r, st_nxt;
  logic [127:0]          buf_r, buf_nxt;
  logic [7:0]            cnt_r, cnt_nxt;
  logic [9:0]            blk_r, blk_nxt;
  logic [9:0]            blklen_r, blklen_nxt;
  logic [9:0]            rem_r, rem_nxt;
  logic [9:0]            fetch_r, fetch_nxt;
  logic [63:0]           out_r, out_nxt;
  logic                  outv_r, outv_nxt;
  logic                  ksr_r, ksr_nxt;
  logic                  start_r, start_nxt;
  logic                  wb_r, wb_nxt;
  logic                  irq_r, irq_nxt;

  // ****************************************************************
  // combinational next state
  // ****************************************************************
  logic        acc, wr, rd;
  logic        clr_all, clr_ctx, busy;
  logic [3:0]  ev;
  logic [6:0]  need;
  logic [127:0] buf_s;
  logic [7:0]  cnt_s;
  logic        emit, take, pop, hold_emit;
  logic        mismatch, do_cmp;
  logic [31:0] wd;
  logic [9:0]  tot;

  // bus decode, register file, sequencing and formatting
  always_comb begin
    acc       = (av_req.read | av_req.write) & ~wait_r;
    wr        = acc & av_req.write;
    rd        = acc & av_req.read;
    wd        = av_req.writedata;
    busy      = (st_r != kmc_pkg::ST_IDLE);
    ev        = 4'h0;
    clr_all   = srst | (wr & (av_req.address == kmc_pkg::OFS_CTRL) & wd[kmc_pkg::CB_SR]);
    clr_ctx   = clr_all | (wr & (av_req.address == kmc_pkg::OFS_CTRL) & wd[kmc_pkg::CB_RI]);
    wait_nxt  = ~((av_req.read | av_req.write) & wait_r);
    rdata_nxt = rdata_r;
    mode_nxt  = mode_r;
    dsize_nxt = dsize_r;
    etag_nxt  = etag_r;
    cfg_nxt   = cfg_r;
    ien_nxt   = ien_r;
    cmp_nxt   = cmp_r;
    st_nxt    = st_r;
    start_nxt = 1'b0;
    wb_nxt    = 1'b0;
    mismatch  = 1'b0;
    do_cmp    = 1'b0;
    tot       = kmc_pkg::SHORT_TOT;
    blklen_nxt = blklen_r;

    // read data latched in the wait cycle, stable at accept
    if (av_req.read & wait_r) begin
      unique case (av_req.address)
        kmc_pkg::OFS_MODE_LO: rdata_nxt = kmc_mode_word(mode_r);
        kmc_pkg::OFS_DSIZE:   rdata_nxt = dsize_r;
        kmc_pkg::OFS_ETAG:    rdata_nxt = 32'(etag_r);
        kmc_pkg::OFS_CTRL:    rdata_nxt = {26'h0, cfg_r, 3'h0};
        kmc_pkg::OFS_STATUS:  rdata_nxt = {26'h0, |ist_r[3:1], ist_r[0], outv_r, cmp_r, busy};
        kmc_pkg::OFS_IRQ_ST:  rdata_nxt = {28'h0, ist_r};
        kmc_pkg::OFS_IRQ_EN:  rdata_nxt = {28'h0, ien_r};
        kmc_pkg::OFS_OUT_HI:  rdata_nxt = outv_r ? out_r[63:32] : 32'h0;
        kmc_pkg::OFS_OUT_LO:  rdata_nxt = outv_r ? out_r[31:0] : 32'h0;
        default:              rdata_nxt = 32'h0;
      endcase
    end

    // register writes
    if (wr) begin
      unique case (av_req.address)
        kmc_pkg::OFS_MODE_HI: begin
          if (busy) begin
            ev[kmc_pkg::IB_CERR] = 1'b1;
          end
          else if (wd != 32'h0) begin
            ev[kmc_pkg::IB_DERR] = 1'b1;
          end
        end
        kmc_pkg::OFS_MODE_LO: begin
          if (busy) begin
            ev[kmc_pkg::IB_CERR] = 1'b1;
          end else begin
            mode_nxt.short_burst_format  = wd[kmc_pkg::MB_SHORT];
            mode_nxt.compare_integrity   = wd[kmc_pkg::MB_CMP];
            mode_nxt.long_burst_format   = wd[kmc_pkg::MB_LONG];
            mode_nxt.final_block_process = wd[kmc_pkg::MB_FINAL];
            mode_nxt.new_message_init    = wd[kmc_pkg::MB_INIT];
            mode_nxt.algorithm_select    = wd[1:0];
            if ((wd & kmc_pkg::MODE_LO_RSV) != 32'h0) begin
              ev[kmc_pkg::IB_DERR] = 1'b1;
            end
            if (wd[kmc_pkg::MB_SHORT] & wd[kmc_pkg::MB_LONG]) begin
              ev[kmc_pkg::IB_DERR] = 1'b1;
            end
            if (wd[0]) begin
              ev[kmc_pkg::IB_DERR] = 1'b1;
            end
          end
        end
        kmc_pkg::OFS_DSIZE: begin
          if (busy) begin
            ev[kmc_pkg::IB_CERR] = 1'b1;
          end else begin
            dsize_nxt = wd;
          end
        end
        kmc_pkg::OFS_ETAG:   etag_nxt = wd[TAG_W-1:0];
        kmc_pkg::OFS_CTRL:   cfg_nxt  = wd[kmc_pkg::CB_LLEN:kmc_pkg::CB_WBA];
        kmc_pkg::OFS_IRQ_EN: ien_nxt  = wd[3:0];
        default: ;
      endcase
    end

    // output word handshake: reading the low half pops it
    pop       = rd & (av_req.address == kmc_pkg::OFS_OUT_LO) & outv_r;
    hold_emit = av_req.read & wait_r & (av_req.address == kmc_pkg::OFS_OUT_LO);
    need      = kmc_need(blk_r);
    emit      = (st_r == kmc_pkg::ST_F8_RUN) & (blk_r != 10'h0) & ({1'b0, need} <= cnt_r)
                & (~outv_r | pop) & ~hold_emit;
    take      = (st_r == kmc_pkg::ST_F8_RUN) & ks_in.valid & ksr_r;
    buf_s     = emit ? (buf_r << need) : buf_r;
    cnt_s     = emit ? (cnt_r - {1'b0, need}) : cnt_r;
    buf_nxt   = take ? (buf_s | ({ks_in.data, 64'h0} >> cnt_s)) : buf_s;
    cnt_nxt   = take ? (cnt_s + 8'h40) : cnt_s;
    fetch_nxt = take ? ((fetch_r > 10'h040) ? (fetch_r - 10'h040) : 10'h0) : fetch_r;
    outv_nxt  = emit | (outv_r & ~pop);
    // tail word keeps top bits, low bits zero
    out_nxt   = emit ? (buf_r[127:64] & ~({64{1'b1}} >> need)) : out_r;
    blk_nxt   = blk_r;
    rem_nxt   = rem_r;
    if (emit) begin
      blk_nxt = blk_r - {3'h0, need};
      rem_nxt = rem_r - {3'h0, need};
      if ((blk_nxt == 10'h0) && (rem_nxt != 10'h0)) begin
        blk_nxt = blklen_r;
      end
    end

    // sequencing
    unique case (st_r)
      kmc_pkg::ST_IDLE: begin
        // data size write starts the unit
        if (wr & (av_req.address == kmc_pkg::OFS_DSIZE)) begin
          if (mode_r.algorithm_select == kmc_pkg::ALG_F8) begin
            st_nxt    = kmc_pkg::ST_F8_RUN;
            start_nxt = 1'b1;
            cmp_nxt   = kmc_pkg::CMP_NONE;
            tot = cfg_r[2] ? kmc_pkg::LONG_TOT : kmc_pkg::SHORT_TOT;
            if (mode_r.short_burst_format) begin
              tot = kmc_pkg::SHORT_TOT;
              blklen_nxt = kmc_pkg::SHORT_BLK;
            end else if (mode_r.long_burst_format) begin
              tot = kmc_pkg::LONG_TOT;
              blklen_nxt = kmc_pkg::LONG_BLK;
            end else begin
              blklen_nxt = tot;
            end
            buf_nxt   = 128'h0;
            cnt_nxt   = 8'h0;
            outv_nxt  = 1'b0;
            blk_nxt   = blklen_nxt;
            rem_nxt   = tot;
            fetch_nxt = tot;
          end else if (mode_r.algorithm_select == kmc_pkg::ALG_F9) begin
            st_nxt    = kmc_pkg::ST_F9_WAIT;
            start_nxt = 1'b1;
            cmp_nxt   = kmc_pkg::CMP_NONE;
          end else begin
            ev[kmc_pkg::IB_DERR] = 1'b1;
          end
        end
      end
      kmc_pkg::ST_F8_RUN: begin
        if (rem_r == 10'h0) begin
          st_nxt = kmc_pkg::ST_IDLE;
          ev[kmc_pkg::IB_DONE] = 1'b1;
          wb_nxt = cfg_r[0] | cfg_r[1];
        end
      end
      kmc_pkg::ST_F9_WAIT: begin
        if (core_done) begin
          st_nxt = kmc_pkg::ST_IDLE;
          // compare only on a completed message
          do_cmp   = mode_r.compare_integrity & mode_r.final_block_process;
          mismatch = do_cmp & (core_tag != etag_r);
          if (do_cmp) begin
            cmp_nxt = mismatch ? kmc_pkg::CMP_FAIL : kmc_pkg::CMP_PASS;
          end
          ev[kmc_pkg::IB_IERR] = mismatch;
          // interrupt mode drops done on mismatch
          if (~(mismatch & ien_r[kmc_pkg::IB_IERR] & ~cfg_r[0] & ~cfg_r[1])) begin
            ev[kmc_pkg::IB_DONE] = 1'b1;
            wb_nxt = cfg_r[0] | cfg_r[1];
          end
        end
      end
    endcase
    ksr_nxt = (st_nxt == kmc_pkg::ST_F8_RUN) & (cnt_nxt <= 8'h40) & (fetch_nxt != 10'h0);

    // sticky status: set wins over write-one clear
    ist_nxt = ist_r;
    if (wr & (av_req.address == kmc_pkg::OFS_IRQ_ST)) begin
      ist_nxt = ist_r & ~wd[3:0];
    end
    if (wr & (av_req.address == kmc_pkg::OFS_CTRL) & wd[kmc_pkg::CB_CLI]) begin
      ist_nxt = 4'h0;
    end
    ist_nxt = ist_nxt | ev;

    // soft reset and re-init clear context
    if (clr_ctx) begin
      mode_nxt  = '0;
      dsize_nxt = 32'h0;
      etag_nxt  = '0;
      cfg_nxt   = 3'h0;
      ist_nxt   = 4'h0;
      cmp_nxt   = kmc_pkg::CMP_NONE;
      st_nxt    = kmc_pkg::ST_IDLE;
      buf_nxt   = 128'h0;
      cnt_nxt   = 8'h0;
      blk_nxt   = 10'h0;
      blklen_nxt = 10'h0;
      rem_nxt   = 10'h0;
      fetch_nxt = 10'h0;
      out_nxt   = 64'h0;
      outv_nxt  = 1'b0;
      ksr_nxt   = 1'b0;
      start_nxt = 1'b0;
      wb_nxt    = 1'b0;
    end
    if (clr_all) begin
      ien_nxt = kmc_pkg::IRQ_EN_RST;
    end
    if (srst) begin
      wait_nxt  = 1'b1;
      rdata_nxt = 32'h0;
    end
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // all state registered here, reset folded into next values
  always_ff @(posedge ref_clk) begin
    wait_r   <= wait_nxt;
    rdata_r  <= rdata_nxt;
    mode_r   <= mode_nxt;
    dsize_r  <= dsize_nxt;
    etag_r   <= etag_nxt;
    cfg_r    <= cfg_nxt;
    ist_r    <= ist_nxt;
    ien_r    <= ien_nxt;
    cmp_r    <= cmp_nxt;
    st_r     <= st_nxt;
    buf_r    <= buf_nxt;
    cnt_r    <= cnt_nxt;
    blk_r    <= blk_nxt;
    blklen_r <= blklen_nxt;
    rem_r    <= rem_nxt;
    fetch_r  <= fetch_nxt;
    out_r    <= out_nxt;
    outv_r   <= outv_nxt;
    ksr_r    <= ksr_nxt;
    start_r  <= start_nxt;
    wb_r     <= wb_nxt;
    irq_r    <= irq_nxt;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // flop outputs to the bus, core and channel
  assign av_waitrequest = wait_r;
  assign av_readdata    = rdata_r;
  assign ks_ready       = ksr_r;
  assign core_start     = start_r;
  assign core_f9        = mode_r.algorithm_select[1];
  assign core_init      = mode_r.new_message_init;
  assign core_final     = mode_r.final_block_process;
  assign core_bits      = dsize_r;
  assign writeback_req  = wb_r;
  assign done_o         = ist_r[kmc_pkg::IB_DONE];
  assign error_o        = |ist_r[3:1];
  assign irq            = irq_r;

endmodule

// [src/kmc_pkg.sv]
package kmc_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [5:0] OFS_MODE_HI = 6'h00;
  localparam logic [5:0] OFS_MODE_LO = 6'h04;
  localparam logic [5:0] OFS_DSIZE   = 6'h08;
  localparam logic [5:0] OFS_ETAG    = 6'h0C;
  localparam logic [5:0] OFS_CTRL    = 6'h10;
  localparam logic [5:0] OFS_STATUS  = 6'h14;
  localparam logic [5:0] OFS_IRQ_ST  = 6'h18;
  localparam logic [5:0] OFS_IRQ_EN  = 6'h1C;
  localparam logic [5:0] OFS_OUT_HI  = 6'h20;
  localparam logic [5:0] OFS_OUT_LO  = 6'h24;

  // ****************************************************************
  // field positions (numeric bit of low mode word)
  // ****************************************************************
  localparam int MB_SHORT = 7;  // big-endian bit 56
  localparam int MB_CMP   = 6;  // big-endian bit 57
  localparam int MB_LONG  = 5;  // big-endian bit 58
  localparam int MB_FINAL = 4;  // big-endian bit 59
  localparam int MB_INIT  = 3;  // big-endian bit 60
  localparam int MB_RSV   = 2;  // big-endian bit 61
  localparam logic [31:0] MODE_LO_RSV = 32'hFFFF_FF04;
  localparam int CB_SR = 0;
  localparam int CB_RI = 1;
  localparam int CB_CLI = 2;
  localparam int CB_WBA = 3;
  localparam int CB_WBB = 4;
  localparam int CB_LLEN = 5;
  localparam int IB_DONE = 0;
  localparam int IB_DERR = 1;
  localparam int IB_CERR = 2;
  localparam int IB_IERR = 3;

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [3:0]  IRQ_EN_RST = 4'h0;
  localparam logic [9:0]  SHORT_BLK  = 10'h072;  // 114 bits
  localparam logic [9:0]  LONG_BLK   = 10'h15C;  // 348 bits
  localparam logic [9:0]  SHORT_TOT  = 10'h0E4;  // 228 bits
  localparam logic [9:0]  LONG_TOT   = 10'h2B8;  // 696 bits
  localparam logic [6:0]  WORD_BITS  = 7'h40;
  localparam logic [1:0]  ALG_F8     = 2'h0;
  localparam logic [1:0]  ALG_F9     = 2'h2;
  localparam logic [1:0]  CMP_NONE   = 2'h0;
  localparam logic [1:0]  CMP_PASS   = 2'h1;
  localparam logic [1:0]  CMP_FAIL   = 2'h2;

  typedef struct packed {
    logic       short_burst_format;
    logic       compare_integrity;
    logic       long_burst_format;
    logic       final_block_process;
    logic       new_message_init;
    logic [1:0] algorithm_select;
  } kmc_mode_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
  } kmc_av_req_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] data;
  } kmc_ks_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_F8_RUN,
    ST_F9_WAIT
  } kmc_state_t;

endpackage

// [test/kmc_checker.sv]
`timescale 1ns/1ps
module kmc_checker (
  input wire logic                 ref_clk,
  input wire logic                 srst,
  input wire kmc_pkg::kmc_av_req_t av_req,
  input wire logic                 av_waitrequest,
  input wire logic                 core_start,
  input wire logic                 writeback_req,
  input wire logic                 done_o,
  input wire logic                 error_o,
  input wire logic                 irq
);
  // ****************************************************************
  // port timing checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // write accepted at a given address
  sequence s_wacc(a);
    av_req.write && !av_waitrequest && av_req.address == a;
  endsequence
  sequence s_err_soon;
    ##[1:3] error_o;
  endsequence

  property p_wait_one;
    (av_req.read || av_req.write) && av_waitrequest |=> !av_waitrequest;
  endproperty
  property p_wait_low;
    !av_waitrequest |=> av_waitrequest;
  endproperty
  property p_rst_out;
    $fell(srst) |-> av_waitrequest && !irq && !done_o && !error_o;
  endproperty
  property p_start_pls;
    core_start |=> !core_start;
  endproperty
  property p_start_why;
    core_start |-> $past(av_req.write && !av_waitrequest && av_req.address == kmc_pkg::OFS_DSIZE);
  endproperty
  property p_derr_hi;
    s_wacc(kmc_pkg::OFS_MODE_HI) ##0 (av_req.writedata != 32'h0) |-> s_err_soon;
  endproperty
  property p_derr_fmt;
    s_wacc(kmc_pkg::OFS_MODE_LO) ##0 (av_req.writedata[7] && av_req.writedata[5]) |-> s_err_soon;
  endproperty
  property p_derr_alg;
    s_wacc(kmc_pkg::OFS_MODE_LO) ##0 av_req.writedata[0] |-> s_err_soon;
  endproperty
  property p_wb_done;
    writeback_req |-> ##[0:2] done_o;
  endproperty

  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
  a_wait_low: assert property (p_wait_low) else $error("waitrequest low too long");
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  a_start_pls: assert property (p_start_pls) else $error("start longer than a pulse");
  a_start_why: assert property (p_start_why) else $error("start without size write");
  a_derr_hi: assert property (p_derr_hi) else $error("upper mode bits gave no error");
  a_derr_fmt: assert property (p_derr_fmt) else $error("both formats gave no error");
  a_derr_alg: assert property (p_derr_alg) else $error("reserved algorithm gave no error");
  a_wb_done: assert property (p_wb_done) else $error("writeback without done");
endmodule

bind kasumi_mode_control kmc_checker u_chk (
  .ref_clk        (ref_clk),
  .srst           (srst),
  .av_req         (av_req),
  .av_waitrequest (av_waitrequest),
  .core_start     (core_start),
  .writeback_req  (writeback_req),
  .done_o         (done_o),
  .error_o        (error_o),
  .irq            (irq)
);

// [test/kmc_core_model.sv]
`timescale 1ns/1ps
module kmc_core_model #(
  parameter logic [31:0] TAG = 32'h1234_ABCD  // arbitrary tag
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             slow,
  input  wire logic             ks_ready,
  input  wire logic             core_start,
  input  wire logic             core_f9,
  output kmc_pkg::kmc_ks_t      ks_in,
  output logic                  core_done,
  output logic [31:0]           core_tag
);
  // ****************************************************************
  // cipher core stand-in
  // ****************************************************************
  logic [4:0] idx_r;
  logic [3:0] dly_r;
  logic       run_r;
  logic       tog_r;
  logic       vld;

  function automatic logic [63:0] word(input logic [4:0] k);
    return 64'h9E37_79B9_7F4A_7C15 ^ {8{3'h5, k}};
  endfunction

  // word counter, stall toggle and tag delay
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      idx_r <= 5'h00;
      dly_r <= 4'h0;
      run_r <= 1'b0;
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      if (dly_r != 4'h0) dly_r <= dly_r - 4'h1;
      if (core_start) begin
        run_r <= 1'b1;
        idx_r <= 5'h00;
        if (core_f9) dly_r <= 4'h6;
      end else if (vld && ks_ready) begin
        idx_r <= idx_r + 5'h01;
      end
    end
  end

  // idle data and tag show inverted values
  // no word offered in the start cycle, so a stale index is never taken
  assign vld       = run_r && !core_start && !(slow && tog_r);
  assign ks_in     = {vld, vld ? word(idx_r) : ~word(idx_r)};
  assign core_done = dly_r == 4'h1;
  assign core_tag  = core_done ? TAG : ~TAG;
endmodule

// [test/tb_kasumi_mode_control.sv]
`timescale 1ns/1ps
module tb_kasumi_mode_control;
  // ****************************************************************
  // bench
  // ****************************************************************
  localparam logic [31:0] T = 32'h1234_ABCD;
  logic                 ref_clk;
  logic                 srst;
  logic                 slow;
  kmc_pkg::kmc_av_req_t av_req;
  logic                 av_waitrequest;
  logic [31:0]          av_readdata;
  kmc_pkg::kmc_ks_t     ks_in;
  logic                 ks_ready;
  logic                 core_done;
  logic [31:0]          core_tag;
  logic                 core_start;
  logic                 core_f9;
  logic                 core_init;
  logic                 core_final;
  logic [31:0]          core_bits;
  logic                 writeback_req;
  logic                 done_o;
  logic                 error_o;
  logic                 irq;
  logic [31:0]          rd;
  int                   n_fail;
  int                   num_checks;
  int                   n_wb;

  kasumi_mode_control dut (.ref_clk(ref_clk), .srst(srst), .av_req(av_req), .av_waitrequest(av_waitrequest),
    .av_readdata(av_readdata), .ks_in(ks_in), .ks_ready(ks_ready), .core_done(core_done), .core_tag(core_tag),
    .core_start(core_start), .core_f9(core_f9), .core_init(core_init), .core_final(core_final),
    .core_bits(core_bits), .writeback_req(writeback_req), .done_o(done_o), .error_o(error_o), .irq(irq));
  kmc_core_model #(.TAG(T)) u_core (.ref_clk(ref_clk), .srst(srst), .slow(slow), .ks_ready(ks_ready),
    .core_start(core_start), .core_f9(core_f9), .ks_in(ks_in), .core_done(core_done), .core_tag(core_tag));

  // clock and writeback pulse count
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (writeback_req) n_wb++;

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus access, held until waitrequest low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    av_req <= '{~w, w, a, d};
    do begin
      @(posedge ref_clk);
    end while (av_waitrequest);
    rd = av_readdata;
    av_req <= '0;
  endtask

  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic wait_st(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      acc(1'b0, kmc_pkg::OFS_STATUS, 32'h0);
      n++;
    end while ((rd & m) == 32'h0 && n < 400);
    if ((rd & m) == 32'h0) n_fail++;
  endtask

  task automatic t_err();
    logic [7:0] dv [5] = '{8'h01, 8'hA0, 8'h04, 8'h01, 8'hDA};
    acc(1'b1, kmc_pkg::OFS_IRQ_EN, 32'h2);
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, k == 0 ? kmc_pkg::OFS_MODE_HI : kmc_pkg::OFS_MODE_LO, {24'h0, dv[k]});
      rchk("data err", kmc_pkg::OFS_IRQ_ST, k == 4 ? 32'h0 : 32'h2);
      chk("irq", irq, k != 4);
      acc(1'b1, kmc_pkg::OFS_IRQ_ST, 32'hF);
    end
    rchk("mode lo", kmc_pkg::OFS_MODE_LO, 32'hDA);
    rchk("mode hi", kmc_pkg::OFS_MODE_HI, 32'h0);
    acc(1'b1, kmc_pkg::OFS_IRQ_EN, 32'h0);
    acc(1'b1, kmc_pkg::OFS_MODE_HI, 32'h1);
    rchk("masked err", kmc_pkg::OFS_IRQ_ST, 32'h2);
    chk("irq masked", irq, 1'b0);
    acc(1'b1, kmc_pkg::OFS_CTRL, 32'h4);
    rchk("cli clear", kmc_pkg::OFS_IRQ_ST, 32'h0);
    acc(1'b1, kmc_pkg::OFS_IRQ_EN, 32'hF);
    acc(1'b1, kmc_pkg::OFS_CTRL, 32'h2);
    rchk("ri mode", kmc_pkg::OFS_MODE_LO, 32'h0);
    rchk("ri en", kmc_pkg::OFS_IRQ_EN, 32'hF);
    acc(1'b1, kmc_pkg::OFS_CTRL, 32'h1);
    rchk("sr en", kmc_pkg::OFS_IRQ_EN, 32'h0);
  endtask

  // keystream run: block length, block count, mode, control
  task automatic f8(input int bl, input int nb, input logic [31:0] mo, input logic [31:0] ct, input bit ctx);
    logic [767:0] s;
    logic [63:0]  w;
    int           pos;
    int           off;
    int           ln;
    for (int k = 0; k < 12; k++) s[767-64*k -: 64] = u_core.word(5'(k));
    pos = 0;
    acc(1'b1, kmc_pkg::OFS_CTRL, ct);
    acc(1'b1, kmc_pkg::OFS_MODE_LO, mo);
    acc(1'b1, kmc_pkg::OFS_DSIZE, 32'h40);
    if (ctx) begin
      acc(1'b1, kmc_pkg::OFS_MODE_LO, 32'h0);
      rchk("ctx err", kmc_pkg::OFS_IRQ_ST, 32'h4);
      rchk("mode kept", kmc_pkg::OFS_MODE_LO, mo);
    end
    for (int b = 0; b < nb; b++) begin
      for (off = 0; off < bl; off += ln) begin
        ln = (bl - off > 64) ? 64 : bl - off;
        wait_st(32'h8);
        acc(1'b0, kmc_pkg::OFS_OUT_HI, 32'h0);
        w[63:32] = rd;
        acc(1'b0, kmc_pkg::OFS_OUT_LO, 32'h0);
        w[31:0] = rd;
        chk("ks word", w, s[767-pos -: 64] & (~64'h0 << (64 - ln)));
        pos += ln;
      end
    end
    rchk("f8 done", kmc_pkg::OFS_IRQ_ST, ctx ? 32'h5 : 32'h1);
    acc(1'b1, kmc_pkg::OFS_IRQ_ST, 32'hF);
  endtask

  // integrity run: expected tag, control, enables, results
  task automatic f9(input logic [31:0] et, input logic [31:0] ct, input logic [31:0] en, input logic [1:0] cr,
                    input logic [31:0] st, input int wb);
    n_wb = 0;
    acc(1'b1, kmc_pkg::OFS_IRQ_EN, en);
    acc(1'b1, kmc_pkg::OFS_CTRL, ct);
    acc(1'b1, kmc_pkg::OFS_ETAG, et);
    acc(1'b1, kmc_pkg::OFS_MODE_LO, 32'h5A);
    acc(1'b1, kmc_pkg::OFS_DSIZE, 32'h75);
    chk("f9 sel", {core_f9, core_init, core_final}, 3'h7);
    wait_st(32'h6);
    chk("size", core_bits, 32'h75);
    chk("cmp", rd[2:1], cr);
    rchk("f9 st", kmc_pkg::OFS_IRQ_ST, st);
    chk("done_o", done_o, st[0]);
    chk("irq", irq, 1'b1);
    chk("wb", n_wb, wb);
    acc(1'b1, kmc_pkg::OFS_IRQ_ST, 32'hF);
    rchk("cleared", kmc_pkg::OFS_IRQ_ST, 32'h0);
    chk("irq off", irq, 1'b0);
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    slow = 1'b0;
    av_req = '0;
    n_fail = 0;
    num_checks = 0;
    n_wb = 0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    rchk("rst mode", kmc_pkg::OFS_MODE_LO, 32'h0);
    t_err();
    slow <= 1'b1;
    f8(114, 2, 32'h88, 32'h0, 1'b1);
    slow <= 1'b0;
    f8(348, 2, 32'h28, 32'h0, 1'b0);
    f8(228, 1, 32'h08, 32'h0, 1'b0);
    f8(696, 1, 32'h08, 32'h20, 1'b0);
    f9(T ^ 32'h1, 32'h0, 32'hF, 2'h2, 32'h8, 0);
    f9(T, 32'h8, 32'h7, 2'h1, 32'h1, 1);
    f9(T ^ 32'h1, 32'h10, 32'h7, 2'h2, 32'h9, 1);
    end_of_test();
  end

  // watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
endmodule
